//--- logic/fsc_capture.sv
// Purpose: Captures fault address and fault status for the exception handler
// Assumes: The pipeline raises take_exception for one cycle per taken exception
// Notes: Registers are read by move_from_special inside the core, no bus
//
// Function
// - Unaligned access loads fault address with the misaligned data address.
// - Peripheral data bus error records the failing data access address.
// - Data storage fault records virtual data effective address.
// - Instruction storage fault records virtual fetch effective address.
// - Data lookaside miss stores the virtual data access address.
// - Instruction lookaside miss stores the virtual fetch address.
// - Fault address is undefined for all other causes.
// - Selector 0x0003 returns fault address, plain or extended read.
// - 32-bit path, wide address: plain read low half, extended upper.
// - 64-bit path: plain read returns whole fault address.
// - Selector 0x0005 returns fault status; all fields read-only.
// - Delay slot flag set for delay slot faults, else clear; resets 0.
// - Cause codes for stream through privileged instruction, 00000 to 00111.
// - Memory management causes use codes 10000 to 10011.
// - Cause-specific field bits 20:26; 64-bit mode adds bit 50.
// - 64-bit unaligned: long flag 1 for long, 0 otherwise.
// - Unaligned: word flag 1 for word, 0 for halfword.
// - Unaligned: store flag 1 for store, 0 for load.
// - Unaligned: bits 22:26 hold the general register index.
`timescale 1ns/1ps
module fsc_capture
  import fsc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Exception report from the pipeline
  input wire logic take_exception,
  input wire fsc_pkg::fsc_event_s fault_event,
  input wire logic [ADDR_W-1:0] fault_data_address,
  input wire logic [ADDR_W-1:0] fault_fetch_address,
  // Move-from-special read port
  input wire fsc_pkg::fsc_read_s read_req,
  output logic [DATA_W-1:0] read_data,
  output logic read_hit,
  // Direct views for the handler logic
  output logic [ADDR_W-1:0] fault_address_register,
  output logic [DATA_W-1:0] fault_status_register
);
  import fsc_pkg::*;

  localparam int HI_W = (ADDR_W > DATA_W) ? (ADDR_W - DATA_W) : 1;

  // Captured state
  logic [ADDR_W-1:0] fault_address;
  logic [4:0] fault_cause_code;
  logic delay_slot_flag;
  logic [6:0] cause_specific_status;
  logic long_access_flag;
  logic [DATA_W-1:0] read_word;

  // Cause-specific bits come from the small packing module
  logic [6:0] next_spec;
  logic next_long;
  fsc_status_pack u_pack (
    .ev(fault_event),
    .spec_bits(next_spec),
    .long_flag(next_long)
  );

  // Fetch-side causes take the fetch address; data-side causes the data address
  wire is_fetch_cause = (fault_event.cause == FSC_CAUSE_INSTR_STORAGE) ||
    (fault_event.cause == FSC_CAUSE_INSTR_TLB_MISS);
  wire is_data_cause = (fault_event.cause == FSC_CAUSE_UNALIGNED) ||
    (fault_event.cause == FSC_CAUSE_DATA_BUS) ||
    (fault_event.cause == FSC_CAUSE_DATA_STORAGE) ||
    (fault_event.cause == FSC_CAUSE_DATA_TLB_MISS);
  // Other causes leave the address as it was; software must not trust it
  wire [ADDR_W-1:0] next_fault_address = is_fetch_cause ? fault_fetch_address :
    is_data_cause ? fault_data_address : fault_address;

  // Address capture, only on a taken exception
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_address <= '0;
    end else if (take_exception) begin
      fault_address <= next_fault_address;
    end
  end

  // Status capture in the same cycle as the address
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fault_cause_code <= FSC_CAUSE_RESET;
      delay_slot_flag <= 1'b0;
      cause_specific_status <= FSC_SPEC_RESET;
      long_access_flag <= 1'b0;
    end else if (take_exception) begin
      fault_cause_code <= fault_event.cause;
      delay_slot_flag <= fault_event.delay_slot;
      cause_specific_status <= next_spec;
      long_access_flag <= (DATA_W == 64) ? next_long : 1'b0;
    end
  end

  // Assemble the status word; reserved positions stay zero
  // Fields count from the most significant end, so the wide word keeps them low
  always_comb begin
    fault_status_register = '0;
    fault_status_register[FSC_POS_CAUSE_LO +: FSC_CAUSE_W] = fault_cause_code;
    fault_status_register[FSC_POS_SPEC_LO +: FSC_SPEC_W] = cause_specific_status;
    fault_status_register[FSC_POS_DELAY_SLOT] = delay_slot_flag;
    if (DATA_W == 64) begin
      fault_status_register[FSC_POS_LONG] = long_access_flag;
    end
  end

  assign fault_address_register = fault_address;

  // Low and high address halves for the narrow data path
  wire [DATA_W-1:0] addr_low;
  wire [DATA_W-1:0] addr_high;
  generate
    if (ADDR_W >= DATA_W) begin : g_low_trunc
      assign addr_low = fault_address[DATA_W-1:0];
    end else begin : g_low_pad
      assign addr_low = {{(DATA_W-ADDR_W){1'b0}}, fault_address};
    end
    if (ADDR_W > DATA_W) begin : g_high
      wire [HI_W-1:0] hi_bits = fault_address[ADDR_W-1:DATA_W];
      assign addr_high = DATA_W'(hi_bits);
    end else begin : g_no_high
      assign addr_high = '0;
    end
  endgenerate

  // Selector decode; extended reads only reach the address register
  wire sel_addr = read_req.valid && (read_req.selector == FSC_SEL_FAULT_ADDRESS);
  wire sel_status = read_req.valid && !read_req.extended &&
    (read_req.selector == FSC_SEL_FAULT_STATUS);

  always_comb begin
    read_word = '0;
    if (sel_addr) begin
      read_word = read_req.extended ? addr_high : addr_low;
    end else if (sel_status) begin
      read_word = fault_status_register;
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      read_data <= '0;
      read_hit <= 1'b0;
    end else begin
      read_data <= read_word;
      read_hit <= sel_addr || sel_status;
    end
  end
endmodule

//--- logic/fsc_pkg.sv
// Purpose: Constants and carrier types for the fault status capture block
// Assumes: Register bit 0 is the most significant, so bit n sits at position 31-n
// Notes: On the wide path bit n sits at 63-n, which lands on the same low positions
package fsc_pkg;
  // Special register selector values
  localparam logic [15:0] FSC_SEL_FAULT_ADDRESS = 16'h0003;
  localparam logic [15:0] FSC_SEL_FAULT_STATUS = 16'h0005;
  localparam int FSC_SEL_W = 16;
  // Field positions in the status word, same low positions on both path widths
  localparam int FSC_POS_CAUSE_LO = 0;
  localparam int FSC_CAUSE_W = 5;
  localparam int FSC_POS_SPEC_LO = 5;
  localparam int FSC_SPEC_W = 7;
  localparam int FSC_POS_DELAY_SLOT = 12;
  localparam int FSC_POS_LONG = 13;
  localparam int FSC_REG_IDX_W = 5;
  // Reset values
  localparam logic [4:0] FSC_CAUSE_RESET = 5'h00;
  localparam logic [6:0] FSC_SPEC_RESET = 7'h00;

  // Fault cause codes
  localparam logic [4:0] FSC_CAUSE_STREAM = 5'h00;
  localparam logic [4:0] FSC_CAUSE_UNALIGNED = 5'h01;
  localparam logic [4:0] FSC_CAUSE_ILLEGAL_OP = 5'h02;
  localparam logic [4:0] FSC_CAUSE_INSTR_BUS = 5'h03;
  localparam logic [4:0] FSC_CAUSE_DATA_BUS = 5'h04;
  localparam logic [4:0] FSC_CAUSE_DIVIDE = 5'h05;
  localparam logic [4:0] FSC_CAUSE_FLOAT = 5'h06;
  localparam logic [4:0] FSC_CAUSE_PRIVILEGED = 5'h07;
  localparam logic [4:0] FSC_CAUSE_DATA_STORAGE = 5'h10;
  localparam logic [4:0] FSC_CAUSE_INSTR_STORAGE = 5'h11;
  localparam logic [4:0] FSC_CAUSE_DATA_TLB_MISS = 5'h12;
  localparam logic [4:0] FSC_CAUSE_INSTR_TLB_MISS = 5'h13;

  // Access size of the faulting access
  typedef enum logic [1:0] {
    FSC_SIZE_HALF,
    FSC_SIZE_WORD,
    FSC_SIZE_LONG
  } fsc_size_e;

  // One exception report from the pipeline
  typedef struct packed {
    logic [4:0] cause;
    logic delay_slot;
    fsc_size_e size;
    logic is_store;
    logic [4:0] reg_index;
  } fsc_event_s;

  // Read request from the move-from-special path
  typedef struct packed {
    logic valid;
    logic extended;
    logic [15:0] selector;
  } fsc_read_s;
endpackage

//--- logic/fsc_status_pack.sv
// Purpose: Builds the cause-specific status bits for one exception report
// Assumes: Only unaligned accesses carry cause-specific status here
// Notes: Combinational; the capture registers live in the top module
`timescale 1ns/1ps
module fsc_status_pack
  import fsc_pkg::*;
(
  // Exception report
  input wire fsc_pkg::fsc_event_s ev,
  // Packed status bits
  output logic [6:0] spec_bits,
  output logic long_flag
);
  import fsc_pkg::*;

  wire is_unaligned = (ev.cause == FSC_CAUSE_UNALIGNED);
  // Word flag, store flag and register index, other causes read zero
  assign spec_bits = is_unaligned ?
    {(ev.size == FSC_SIZE_WORD), ev.is_store, ev.reg_index} :
    FSC_SPEC_RESET;
  // Long access flag only matters in the wide status layout
  assign long_flag = is_unaligned && (ev.size == FSC_SIZE_LONG);
endmodule

//--- tb/fsc_capture_sva.sv
// Purpose: Port checker for the fault capture block
// Assumes: 32-bit data path, address width of at least 32
// Notes: Status positions are little-endian, cause in bits 4:0
`timescale 1ns/1ps
module fsc_capture_chk
  import fsc_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic take_exception,
  input wire fsc_pkg::fsc_event_s fault_event,
  input wire logic [ADDR_W-1:0] fault_data_address,
  input wire logic [ADDR_W-1:0] fault_fetch_address,
  input wire fsc_pkg::fsc_read_s read_req,
  input wire logic [DATA_W-1:0] read_data,
  input wire logic read_hit,
  input wire logic [ADDR_W-1:0] fault_address_register,
  input wire logic [DATA_W-1:0] fault_status_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Capture relations, one edge after the taken exception
  a_cause_code: assert property (
    take_exception |=> fault_status_register[4:0] == $past(fault_event.cause))
    else $error("cause code not captured");
  a_delay_slot: assert property (
    take_exception |=> fault_status_register[12] == $past(fault_event.delay_slot))
    else $error("delay slot flag wrong");
  a_data_address: assert property (
    take_exception && fault_event.cause inside {5'h01, 5'h04, 5'h10, 5'h12}
    |=> fault_address_register == $past(fault_data_address))
    else $error("data address not captured");
  a_fetch_address: assert property (
    take_exception && fault_event.cause inside {5'h11, 5'h13}
    |=> fault_address_register == $past(fault_fetch_address))
    else $error("fetch address not captured");
  // Word flag, store flag and register index sit in bits 11:5
  a_unaligned_status: assert property (
    take_exception && fault_event.cause == 5'h01
    |=> fault_status_register[11:5] == {($past(fault_event.size) == FSC_SIZE_WORD),
    $past(fault_event.is_store), $past(fault_event.reg_index)})
    else $error("unaligned status wrong");
  a_other_status: assert property (
    take_exception && fault_event.cause != 5'h01 |=> fault_status_register[11:5] == '0)
    else $error("status bits set for other cause");
  // Bit 13 carries the long flag only on the wide path
  a_reserved_zero: assert property (
    fault_status_register[DATA_W-1:14] == '0 && (DATA_W == 64 || !fault_status_register[13]))
    else $error("reserved status bits set");
  a_hold_quiet: assert property (
    !take_exception && !sys_rst
    |=> $stable(fault_address_register) && $stable(fault_status_register))
    else $error("registers changed without exception");
  a_read_status: assert property (
    read_req.valid && !read_req.extended && read_req.selector == FSC_SEL_FAULT_STATUS
    |=> read_hit && read_data == $past(fault_status_register))
    else $error("status read wrong");
  a_read_address: assert property (
    read_req.valid && !read_req.extended && read_req.selector == FSC_SEL_FAULT_ADDRESS
    |=> read_hit && read_data == $past(fault_address_register[31:0]))
    else $error("address read wrong");
  // Extended address read gives the bits above the data path, zero-extended
  a_read_upper: assert property (
    read_req.valid && read_req.extended && read_req.selector == FSC_SEL_FAULT_ADDRESS
    |=> read_hit && read_data == DATA_W'($past(fault_address_register) >> 32))
    else $error("upper address read wrong");
  // Extended read of the status selector is refused
  a_read_refused: assert property (
    read_req.valid && read_req.extended && read_req.selector == FSC_SEL_FAULT_STATUS
    |=> !read_hit && read_data == '0)
    else $error("refused read answered");
endmodule
bind fsc_capture fsc_capture_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .take_exception(take_exception),
  .fault_event(fault_event),
  .fault_data_address(fault_data_address),
  .fault_fetch_address(fault_fetch_address),
  .read_req(read_req),
  .read_data(read_data),
  .read_hit(read_hit),
  .fault_address_register(fault_address_register),
  .fault_status_register(fault_status_register)
);

//--- tb/tb_fsc_capture.sv
// Purpose: Self-checking bench for the fault capture block
// Assumes: Read answer lands one edge after the request
// Notes: 40-bit address on a 32-bit path exercises the extended read
`timescale 1ns/1ps
module tb_fsc_capture;
  import fsc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic take_exception = 1'b0;
  fsc_event_s fault_event = '0;
  logic [39:0] fault_data_address = '0;
  logic [39:0] fault_fetch_address = '0;
  fsc_read_s read_req = '0;
  logic [31:0] read_data;
  logic read_hit;
  logic [39:0] fault_address_register;
  logic [31:0] fault_status_register;
  int fail_count = 0;
  int tests_run = 0;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  fsc_capture #(.DATA_W(32), .ADDR_W(40)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .take_exception(take_exception), .fault_event(fault_event),
    .fault_data_address(fault_data_address), .fault_fetch_address(fault_fetch_address),
    .read_req(read_req), .read_data(read_data), .read_hit(read_hit),
    .fault_address_register(fault_address_register),
    .fault_status_register(fault_status_register));
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Raises take_exception for one edge; the caller lowers it, so back-to-back stays legal
  task automatic take(input logic [4:0] c, input logic ds, input fsc_size_e sz, input logic st,
      input logic [4:0] ri);
    fault_event = '{c, ds, sz, st, ri};
    take_exception = 1'b1;
    @(negedge clk);
  endtask
  // One read; an idle edge after it keeps a following read from reassigning read_req at once
  task automatic rd(input logic ext, input logic [15:0] sel, input logic hit,
      input logic [31:0] exp);
    read_req = '{1'b1, ext, sel};
    @(negedge clk);
    check("read_hit", read_hit, hit);
    check("read_data", read_data, exp);
    read_req = '0;
    @(negedge clk);
  endtask
  task automatic t_causes();
    logic [4:0] codes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h10,
      5'h11, 5'h12, 5'h13};
    logic [39:0] a;
    foreach (codes[i]) begin
      fault_data_address = 40'hd0_8000_0000 | 40'(i);
      fault_fetch_address = 40'h1f_0000_1000 | 40'(i);
      take(codes[i], 1'b0, FSC_SIZE_HALF, 1'b0, 5'h00);
      take_exception = 1'b0;
      rd(1'b0, 16'h0005, 1'b1, {27'h0, codes[i]});
      if (codes[i] inside {5'h01, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13}) begin
        a = (codes[i] inside {5'h11, 5'h13}) ? fault_fetch_address : fault_data_address;
        rd(1'b0, 16'h0003, 1'b1, a[31:0]);
        rd(1'b1, 16'h0003, 1'b1, {24'h0, a[39:32]});
      end
    end
  endtask
  // Three exceptions on consecutive edges, each checked as it lands
  task automatic t_back_to_back();
    take(5'h01, 1'b1, FSC_SIZE_WORD, 1'b1, 5'h1a);
    check("status", fault_status_register, 32'h0000_1f41);
    take(5'h01, 1'b0, FSC_SIZE_HALF, 1'b0, 5'h03);
    check("status", fault_status_register, 32'h0000_0061);
    take(5'h05, 1'b1, FSC_SIZE_WORD, 1'b1, 5'h1f);
    take_exception = 1'b0;
    check("status", fault_status_register, 32'h0000_1005);
  endtask
  task automatic t_hold_and_miss();
    logic [39:0] a = fault_address_register;
    logic [31:0] s = fault_status_register;
    fault_data_address = 40'h55_5555_5555;
    rd(1'b1, 16'h0005, 1'b0, 32'h0000_0000);
    rd(1'b0, 16'h0007, 1'b0, 32'h0000_0000);
    check("held address", fault_address_register, a);
    check("held status", fault_status_register, s);
  endtask
  // Main sequence: reset for two edges, then each scenario
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check("reset status", fault_status_register, 32'h0000_0000);
    t_causes();
    t_back_to_back();
    t_hold_and_miss();
    tally_and_finish();
  end
endmodule
